/* design/fbp_flash_protect.sv */
`timescale 1ns/1ps
`default_nettype none

module fbp_flash_protect #(
    parameter logic [7:0] DEVICE_ID = 8'h5A  // Arbitrary value
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic [3:0] sio_in,
    input wire logic quad_mode_in,
    input wire logic busy_in,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe_out,
    output logic [47:0] protect_map_out,
    output logic [47:0] lock_map_out,
    output logic wel_out,
    output logic deep_sleep_out
);
    localparam int ENTRY_BOUND = fbp_pkg::SLEEP_CYC;
    localparam int WAKE_BOUND = fbp_pkg::WAKE_CYC;

    // Pins are sampled twice before use; the serial clock is oversampled
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic sck_d_r;
    logic csn_d_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_r <= fbp_pkg::SYNC_RST;
            sync2_r <= fbp_pkg::SYNC_RST;
            sck_d_r <= 1'b0;
            csn_d_r <= 1'b1;
        end else begin
            sync1_r <= {quad_mode_in, sio_in, cs_n_in, sck_in};
            sync2_r <= sync1_r;
            sck_d_r <= sync2_r[0];
            csn_d_r <= sync2_r[1];
        end
    end

    logic sck_s;
    logic csn_s;
    logic [3:0] sio_s;
    logic quad_s;
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;

    always_comb begin
        sck_s = sync2_r[0];
        csn_s = sync2_r[1];
        sio_s = sync2_r[5:2];
        quad_s = sync2_r[6];
        rise = sck_s & ~sck_d_r & ~csn_s;
        fall = ~sck_s & sck_d_r & ~csn_s;
        cs_rise = csn_s & ~csn_d_r;
        cs_fall = ~csn_s & csn_d_r;
    end

    // Frame decoder and protection state
    fbp_pkg::fbp_frame_type st_r, st_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic [7:0] opc_r, opc_nxt;
    logic [47:0] data_r, data_nxt;
    logic [47:0] map_r, map_nxt;
    logic [47:0] lock_r, lock_nxt;
    logic wel_r, wel_nxt;
    logic sleep_r, sleep_nxt;
    logic ent_r, ent_nxt;
    logic wake_r, wake_nxt;
    logic [9:0] tmr_r, tmr_nxt;
    logic quad_r, quad_nxt;
    logic [7:0] opc_full;
    logic [6:0] step;
    logic [6:0] cnt_sum;
    logic asleep;
    logic start_rd;
    logic start_id;
    logic do_unlock;
    logic do_sleep;
    logic do_wake;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        opc_nxt = opc_r;
        data_nxt = data_r;
        map_nxt = map_r;
        lock_nxt = lock_r;
        wel_nxt = wel_r;
        sleep_nxt = sleep_r;
        ent_nxt = ent_r;
        wake_nxt = wake_r;
        tmr_nxt = tmr_r;
        quad_nxt = quad_r;
        start_rd = 1'b0;
        start_id = 1'b0;
        do_unlock = 1'b0;
        do_sleep = 1'b0;
        do_wake = 1'b0;
        asleep = sleep_r | ent_r;
        step = quad_r ? 7'h04 : 7'h01;
        cnt_sum = 7'(cnt_r + step);
        opc_full = quad_r ? {opc_r[3:0], sio_s} : {opc_r[6:0], sio_s[0]};

        // Load counts are shortened by two: the load cycle and the final step
        if (ent_r) begin
            if (tmr_r == 10'h000) begin
                ent_nxt = 1'b0;
                sleep_nxt = 1'b1;
            end else begin
                tmr_nxt = tmr_r - 10'h001;
            end
        end
        if (wake_r) begin
            if (tmr_r == 10'h000) begin
                wake_nxt = 1'b0;
                sleep_nxt = 1'b0;
            end else begin
                tmr_nxt = tmr_r - 10'h001;
            end
        end

        case (st_r)
            fbp_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    st_nxt = fbp_pkg::ST_OPC;
                    cnt_nxt = 7'h00;
                    quad_nxt = quad_s;
                end
            end
            fbp_pkg::ST_OPC: begin
                if (rise) begin
                    opc_nxt = opc_full;
                    cnt_nxt = cnt_sum;
                    if (cnt_sum == fbp_pkg::OPC_BITS) begin
                        if (wake_r || (asleep && opc_full != fbp_pkg::OPC_WAKE)) begin
                            st_nxt = fbp_pkg::ST_SKIP;
                        end else begin
                            case (opc_full)
                                fbp_pkg::OPC_MAPR: begin
                                    st_nxt = fbp_pkg::ST_OUT;
                                    start_rd = 1'b1;
                                end
                                fbp_pkg::OPC_WAKE: begin
                                    st_nxt = fbp_pkg::ST_OUT;
                                    start_id = 1'b1;
                                end
                                fbp_pkg::OPC_MAPW, fbp_pkg::OPC_PLOCK: begin
                                    st_nxt = fbp_pkg::ST_DATA;
                                    cnt_nxt = 7'h00;
                                end
                                default: begin
                                    st_nxt = fbp_pkg::ST_DONE;
                                end
                            endcase
                        end
                    end
                end
            end
            fbp_pkg::ST_DATA: begin
                // Most significant bits first; bits beyond the map are dropped
                if (rise && cnt_r < fbp_pkg::MAP_BITS) begin
                    data_nxt = quad_r ? {data_r[43:0], sio_s} : {data_r[46:0], sio_s[0]};
                    cnt_nxt = cnt_sum;
                end
            end
            fbp_pkg::ST_DONE: begin
                // Anything after a bare opcode spoils the frame
                if (rise) begin
                    st_nxt = fbp_pkg::ST_SKIP;
                end
            end
            default: begin
            end
        endcase

        if (cs_rise) begin
            st_nxt = fbp_pkg::ST_IDLE;
            case (st_r)
                fbp_pkg::ST_DONE: begin
                    case (opc_r)
                        fbp_pkg::OPC_WLS: begin
                            wel_nxt = 1'b1;
                        end
                        fbp_pkg::OPC_WDIS: begin
                            wel_nxt = 1'b0;
                        end
                        fbp_pkg::OPC_UNLOCK: begin
                            if (wel_r) begin
                                map_nxt = map_r & ~(fbp_pkg::WLOCK_MASK & ~lock_r);
                                wel_nxt = 1'b0;
                                do_unlock = 1'b1;
                            end
                        end
                        fbp_pkg::OPC_SLEEP: begin
                            if (!busy_in) begin
                                ent_nxt = 1'b1;
                                tmr_nxt = 10'(fbp_pkg::SLEEP_CYC - 2);
                                do_sleep = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                fbp_pkg::ST_DATA: begin
                    if (cnt_r == fbp_pkg::MAP_BITS && wel_r) begin
                        wel_nxt = 1'b0;
                        if (opc_r == fbp_pkg::OPC_MAPW) begin
                            map_nxt = (data_r & ~(fbp_pkg::WLOCK_MASK & lock_r))
                                | (map_r & fbp_pkg::WLOCK_MASK & lock_r);
                        end else begin
                            // One-time programmable: bits only ever set
                            lock_nxt = lock_r | (data_r & fbp_pkg::WLOCK_MASK);
                        end
                    end
                end
                fbp_pkg::ST_OUT: begin
                    if (opc_r == fbp_pkg::OPC_WAKE && asleep) begin
                        ent_nxt = 1'b0;
                        wake_nxt = 1'b1;
                        tmr_nxt = 10'(fbp_pkg::WAKE_CYC - 2);
                        do_wake = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= fbp_pkg::ST_IDLE;
            cnt_r <= 7'h00;
            opc_r <= 8'h00;
            data_r <= fbp_pkg::LOCK_RST;
            map_r <= fbp_pkg::MAP_RST;
            lock_r <= fbp_pkg::LOCK_RST;
            wel_r <= 1'b0;
            sleep_r <= 1'b0;
            ent_r <= 1'b0;
            wake_r <= 1'b0;
            tmr_r <= 10'h000;
            quad_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            opc_r <= opc_nxt;
            data_r <= data_nxt;
            map_r <= map_nxt;
            lock_r <= lock_nxt;
            wel_r <= wel_nxt;
            sleep_r <= sleep_nxt;
            ent_r <= ent_nxt;
            wake_r <= wake_nxt;
            tmr_r <= tmr_nxt;
            quad_r <= quad_nxt;
        end
    end

    // Output word: {drive enable, nibble}; single-wire mode uses bit 0 only.
    // Bit 47:46 pair is the top 8K block, 33:32 the bottom one.
    function automatic logic [4:0] out_word(input logic is_id, input logic q,
                                            input logic [6:0] i, input logic [47:0] m);
        logic [6:0] k;
        logic [8:0] sh_amt;
        logic [47:0] msh;
        logic [7:0] ish;
        out_word = 5'h00;
        k = 7'h00;
        sh_amt = 9'h000;
        msh = 48'h0;
        ish = 8'h00;
        if (is_id) begin
            if (i >= fbp_pkg::ID_DUMMY) begin
                k = 7'(i - fbp_pkg::ID_DUMMY);
                ish = q ? DEVICE_ID << {k[0], 2'b00} : DEVICE_ID << k[2:0];
                out_word = {1'b1, q ? ish[7:4] : {3'b000, ish[7]}};
            end
        end else if (!q || i >= fbp_pkg::RD_DUMMY_QUAD) begin
            k = q ? 7'(i - fbp_pkg::RD_DUMMY_QUAD) : i;
            sh_amt = q ? {k, 2'b00} : {2'b00, k};
            // Shifting past the map leaves zeros, as the read demands
            msh = m << sh_amt;
            out_word = {1'b1, q ? msh[47:44] : {3'b000, msh[47]}};
        end
    endfunction : out_word

    // Producer feeds the FIFO ahead of the host's falling edges
    fbp_stream_if #(.W(fbp_pkg::WORD_W)) prod_if ();
    fbp_stream_if #(.W(fbp_pkg::WORD_W)) cons_if ();

    logic out_on_r, out_on_nxt;
    logic out_id_r, out_id_nxt;
    logic [6:0] idx_r, idx_nxt;
    logic [3:0] dout_r, dout_nxt;
    logic [3:0] doe_r, doe_nxt;

    always_comb begin
        out_on_nxt = out_on_r;
        out_id_nxt = out_id_r;
        idx_nxt = idx_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        prod_if.valid = out_on_r;
        prod_if.data = out_word(out_id_r, quad_r, idx_r, map_r);
        cons_if.ready = fall;
        if (start_rd || start_id) begin
            out_on_nxt = 1'b1;
            out_id_nxt = start_id;
            idx_nxt = 7'h00;
        end else if (out_on_r && prod_if.ready) begin
            if (out_id_r && idx_r == fbp_pkg::ID_WRAP) begin
                idx_nxt = fbp_pkg::ID_DUMMY;
            end else if (idx_r != fbp_pkg::IDX_MAX) begin
                idx_nxt = idx_r + 7'h01;
            end
        end
        if (fall && cons_if.valid) begin
            if (quad_r) begin
                dout_nxt = cons_if.data[3:0];
                doe_nxt = {4{cons_if.data[4]}};
            end else begin
                dout_nxt = {2'b00, cons_if.data[0], 1'b0};
                doe_nxt = {2'b00, cons_if.data[4], 1'b0};
            end
        end
        if (csn_s) begin
            out_on_nxt = 1'b0;
            dout_nxt = 4'h0;
            doe_nxt = 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_on_r <= 1'b0;
            out_id_r <= 1'b0;
            idx_r <= 7'h00;
            dout_r <= 4'h0;
            doe_r <= 4'h0;
        end else begin
            out_on_r <= out_on_nxt;
            out_id_r <= out_id_nxt;
            idx_r <= idx_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
        end
    end

    fbp_fifo #(.W(fbp_pkg::WORD_W), .DEPTH(fbp_pkg::FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .flush_in(cs_rise | cs_fall),
        .in_if(prod_if.sink),
        .out_if(cons_if.source)
    );

    always_comb begin
        sio_out = dout_r;
        sio_oe_out = doe_r;
        protect_map_out = map_r;
        lock_map_out = lock_r;
        wel_out = wel_r;
        deep_sleep_out = sleep_r;
    end

    a_map_reset_default: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> map_r == fbp_pkg::MAP_RST)
        else $error("protection map not at default after reset");
    a_unlock_clears: assert property (@(posedge clk_in) disable iff (rst_in)
        do_unlock |=> (map_r & fbp_pkg::WLOCK_MASK & ~lock_r) == 48'h0)
        else $error("unlock left an unlocked write bit set");
    a_unlock_needs_wel: assert property (@(posedge clk_in) disable iff (rst_in)
        (cs_rise && st_r == fbp_pkg::ST_DONE && opc_r == fbp_pkg::OPC_UNLOCK && !wel_r)
        |=> $stable(map_r))
        else $error("unlock acted without write latch");
    a_lock_kept: assert property (@(posedge clk_in) disable iff (rst_in)
        ##1 ((map_r ^ $past(map_r)) & $past(lock_r) & fbp_pkg::WLOCK_MASK) == 48'h0)
        else $error("locked-down protection bit changed");
    a_wel_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
        do_unlock |=> !wel_r [*2])
        else $error("write latch survived unlock");
    a_sleep_busy: assert property (@(posedge clk_in) disable iff (rst_in)
        (cs_rise && st_r == fbp_pkg::ST_DONE && opc_r == fbp_pkg::OPC_SLEEP && busy_in)
        |=> !ent_r && !sleep_r)
        else $error("sleep entered while busy");
    a_sleep_entry: assert property (@(posedge clk_in) disable iff (rst_in)
        do_sleep |-> ##[1:ENTRY_BOUND] sleep_r)
        else $error("sleep entry delay exceeded");
    a_sleep_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
        (sleep_r && cs_rise && st_r != fbp_pkg::ST_OUT) |=> $stable(map_r) && $stable(wel_r))
        else $error("command acted during deep sleep");
    a_wake_release: assert property (@(posedge clk_in) disable iff (rst_in)
        do_wake |-> ##[1:WAKE_BOUND] !sleep_r)
        else $error("wake delay exceeded");
    a_pins_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        csn_s |=> sio_oe_out == 4'h0)
        else $error("output driven with select high");

endmodule : fbp_flash_protect

`default_nettype wire

/* design/fbp_pkg.sv */
package fbp_pkg;

    // Command codes
    localparam logic [7:0] OPC_WLS = 8'h06;
    localparam logic [7:0] OPC_WDIS = 8'h04;
    localparam logic [7:0] OPC_UNLOCK = 8'h98;
    localparam logic [7:0] OPC_SLEEP = 8'hB9;
    localparam logic [7:0] OPC_WAKE = 8'hAB;
    localparam logic [7:0] OPC_MAPW = 8'h42;
    localparam logic [7:0] OPC_MAPR = 8'h72;
    localparam logic [7:0] OPC_PLOCK = 8'hE8;

    // Protection map layout and power-on value
    localparam int MAP_W = 48;
    localparam logic [47:0] MAP_RST = 48'h5555_FFFF_FFFF;
    // Every even bit of the upper 16 plus bits 31:0 are write locks
    localparam logic [47:0] WLOCK_MASK = 48'h5555_FFFF_FFFF;
    localparam logic [47:0] LOCK_RST = 48'h0000_0000_0000;

    // Frame bit counts
    localparam logic [6:0] OPC_BITS = 7'h08;
    localparam logic [6:0] MAP_BITS = 7'h30;
    localparam logic [6:0] ID_DUMMY = 7'h03;
    localparam logic [6:0] RD_DUMMY_QUAD = 7'h02;
    localparam logic [6:0] ID_WRAP = 7'h0A;
    localparam logic [6:0] IDX_MAX = 7'h7F;

    // Synchroniser rest value: quad, sio[3:0], cs_n, sck
    localparam logic [6:0] SYNC_RST = 7'h02;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int SLEEP_ENTRY_US = 3;
    localparam int WAKE_US = 10;
    localparam int SLEEP_CYC = SLEEP_ENTRY_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;

    // Output stream
    localparam int WORD_W = 5;
    localparam int FIFO_DEPTH = 8;

    typedef enum {ST_IDLE, ST_OPC, ST_DATA, ST_DONE, ST_OUT, ST_SKIP} fbp_frame_type;

endpackage : fbp_pkg

/* design/fbp_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface fbp_stream_if #(parameter int W = 5) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : fbp_stream_if

`default_nettype wire

/* design/fbp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

// DEPTH must be a power of two
module fbp_fifo #(
    parameter int W = 5,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    fbp_stream_if.sink in_if,
    fbp_stream_if.source out_if
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic [AW:0] wr_nxt;
    logic [AW:0] rd_nxt;
    logic full;
    logic empty;
    logic push;
    logic pop;

    always_comb begin
        full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
        empty = (wr_r == rd_r);
        push = in_if.valid & ~full;
        pop = out_if.ready & ~empty;
        in_if.ready = ~full;
        out_if.valid = ~empty;
        out_if.data = mem_r[rd_r[AW-1:0]];
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || flush_in) begin
            wr_r <= {(AW + 1){1'b0}};
            rd_r <= {(AW + 1){1'b0}};
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_if.data;
        end
    end

endmodule : fbp_fifo

`default_nettype wire

/* sim/fbp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fbp_host_model (
    input wire logic clk_in,
    input wire logic [3:0] dev_sio_in,
    input wire logic [3:0] dev_oe_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic quad_out,
    output logic [3:0] sio_out
);
    logic [3:0] dq;
    logic [3:0] host_v;
    logic on;
    logic tog;

    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        quad_out = 1'b0;
        dq = 4'h0;
        on = 1'b0;
        tog = 1'b0;
    end

    // Released lines toggle every cycle so a stale level never passes for data
    always @(posedge clk_in) begin
        tog <= ~tog;
    end

    assign host_v = !on ? {~tog, tog, ~tog, tog} : (quad_out ? dq : {~tog, tog, ~tog, dq[0]});
    assign sio_out = (dev_oe_in & dev_sio_in) | (~dev_oe_in & host_v);

    // Mode 0 frame: nw data bits, nd dummy clocks, nr bits (quad: nibbles) read
    task automatic xfer(input logic q, input logic [7:0] opc, input logic [47:0] wd,
                        input int nw, input int nd, input int nr, output logic [63:0] rd);
        int i;
        int nc;
        logic [55:0] sh;
        rd = 64'h0;
        sh = {opc, wd};
        nc = q ? 2 + nw / 4 : 8 + nw;
        quad_out <= q;
        cs_n_out <= 1'b0;
        for (i = 0; i < nc + nd + nr; i++) begin
            dq <= q ? sh[55:52] : {3'b000, sh[55]};
            on <= (i < nc);
            sh = q ? sh << 4 : sh << 1;
            // Low phase alternates 6 and 7 cycles for a 125 ns average period
            repeat (6 + i % 2) @(posedge clk_in);
            if (i >= nc + nd) begin
                rd = q ? {rd[59:0], sio_out} : {rd[62:0], sio_out[1]};
            end
            sck_out <= 1'b1;
            repeat (6) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        repeat (6) @(posedge clk_in);
        cs_n_out <= 1'b1;
        on <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask : xfer
endmodule : fbp_host_model

`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [7:0] ID = 8'hC3; // Arbitrary value
    localparam logic [47:0] LOCKS = 48'h4000_4000_0001;
    logic clk_in;
    logic rst_in;
    logic busy;
    logic sleep;
    logic wel;
    logic cs_n;
    logic sck;
    logic quad;
    logic [3:0] line;
    logic [3:0] dout;
    logic [3:0] doe;
    logic [47:0] pmap;
    logic [47:0] lmap;
    logic [63:0] rd;
    int fail_count;
    int checked;

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    fbp_host_model host_u (.clk_in(clk_in), .dev_sio_in(dout), .dev_oe_in(doe),
        .cs_n_out(cs_n), .sck_out(sck), .quad_out(quad), .sio_out(line));

    fbp_flash_protect #(.DEVICE_ID(ID)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .cs_n_in(cs_n), .sck_in(sck), .sio_in(line), .quad_mode_in(quad), .busy_in(busy),
        .sio_out(dout), .sio_oe_out(doe), .protect_map_out(pmap), .lock_map_out(lmap),
        .wel_out(wel), .deep_sleep_out(sleep));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmd(input logic [7:0] op);
        host_u.xfer(1'b0, op, 48'h0, 0, 0, 0, rd);
    endtask : cmd

    task automatic wait_sleep(input logic v, input int lim);
        int n;
        n = 0;
        while (sleep !== v && n < lim) begin
            @(posedge clk_in);
            n++;
        end
        chk({63'h0, sleep}, {63'h0, v});
        if (sleep !== v) begin
            report_and_stop();
        end
    endtask : wait_sleep

    task automatic test_reset;
        chk(pmap, fbp_pkg::MAP_RST);
        chk(lmap, fbp_pkg::LOCK_RST);
        chk({wel, sleep}, 2'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_read;
        host_u.xfer(1'b0, fbp_pkg::OPC_MAPR, 48'h0, 0, 0, 56, rd);
        chk(rd[55:0], {fbp_pkg::MAP_RST, 8'h00});
        $display("test_read done");
    endtask : test_read

    task automatic test_no_latch;
        cmd(fbp_pkg::OPC_UNLOCK);
        chk(pmap, fbp_pkg::MAP_RST);
        $display("test_no_latch done");
    endtask : test_no_latch

    task automatic test_lock_unlock;
        cmd(fbp_pkg::OPC_WLS);
        chk(wel, 1'h1);
        host_u.xfer(1'b0, fbp_pkg::OPC_PLOCK, LOCKS, 48, 0, 0, rd);
        chk(lmap, LOCKS & fbp_pkg::WLOCK_MASK);
        cmd(fbp_pkg::OPC_WLS);
        chk(wel, 1'h1);
        cmd(fbp_pkg::OPC_UNLOCK);
        chk(pmap, fbp_pkg::MAP_RST & (~fbp_pkg::WLOCK_MASK | LOCKS));
        chk(wel, 1'h0);
        $display("test_lock_unlock done");
    endtask : test_lock_unlock

    task automatic test_map_write;
        logic [47:0] want;
        // Locked-down bits keep what the unlock left: the power-on value
        want = (48'hAAAA_0000_0000 & ~LOCKS) | (fbp_pkg::MAP_RST & LOCKS);
        cmd(fbp_pkg::OPC_WLS);
        host_u.xfer(1'b0, fbp_pkg::OPC_MAPW, 48'hAAAA_0000_0000, 48, 0, 0, rd);
        chk(pmap, want);
        host_u.xfer(1'b0, fbp_pkg::OPC_MAPR, 48'h0, 0, 0, 48, rd);
        chk(rd[47:0], want);
        host_u.xfer(1'b1, fbp_pkg::OPC_MAPR, 48'h0, 0, 2, 14, rd);
        chk(rd[55:0], {want, 8'h00});
        cmd(fbp_pkg::OPC_WLS);
        host_u.xfer(1'b1, fbp_pkg::OPC_MAPW, 48'h1111_2222_3333, 48, 0, 0, rd);
        chk(pmap, (48'h1111_2222_3333 & ~LOCKS) | (fbp_pkg::MAP_RST & LOCKS));
        $display("test_map_write done");
    endtask : test_map_write

    task automatic test_busy_sleep;
        busy <= 1'b1;
        cmd(fbp_pkg::OPC_SLEEP);
        repeat (400) @(posedge clk_in);
        chk(sleep, 1'h0);
        busy <= 1'b0;
        $display("test_busy_sleep done");
    endtask : test_busy_sleep

    task automatic test_sleep_wake;
        cmd(fbp_pkg::OPC_SLEEP);
        wait_sleep(1'b1, 310);
        cmd(fbp_pkg::OPC_WLS);
        chk(wel, 1'h0);
        host_u.xfer(1'b0, fbp_pkg::OPC_WAKE, 48'h0, 0, 3, 16, rd);
        chk(rd[15:0], {ID, ID});
        wait_sleep(1'b0, 1010);
        repeat (1000) @(posedge clk_in);
        cmd(fbp_pkg::OPC_WLS);
        chk(wel, 1'h1);
        $display("test_sleep_wake done");
    endtask : test_sleep_wake

    initial begin
        rst_in = 1'b1;
        busy = 1'b0;
        fail_count = 0;
        checked = 0;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (10000) @(posedge clk_in);
        test_reset();
        test_read();
        test_no_latch();
        test_lock_unlock();
        test_map_write();
        test_busy_sleep();
        test_sleep_wake();
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
